// >>> inc/spm_defs.svh
/*
 Constants of the scan-port memory programming link: link register
 selects, the unlock key, command opcodes, memory geometry and timing.
 Assumes inclusion by bare name from the package and both ends.
*/
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

// ----------------------------------------------------------------------
// Link register selects and lengths
// ----------------------------------------------------------------------
`define SPM_SEL_RST      2'h0
`define SPM_SEL_KEY      2'h1
`define SPM_SEL_CMD      2'h2
`define SPM_LEN_RST      5'h01
`define SPM_LEN_KEY      5'h10
`define SPM_LEN_CMD      5'h0F
`define SPM_SHIFT_W      5'h10

// ----------------------------------------------------------------------
// Unlock key and command opcodes (upper seven bits)
// ----------------------------------------------------------------------
`define SPM_KEY          16'hA370
`define SPM_OP_ENTER     7'h23
`define SPM_OP_ADDR_HI   7'h07
`define SPM_OP_ADDR_LO   7'h03
`define SPM_OP_DATA_LO   7'h13
`define SPM_OP_DATA_HI   7'h17
`define SPM_OP_LATCH     7'h77
`define SPM_OP_POLL_F    7'h37
`define SPM_OP_WRITE_F   7'h35
`define SPM_OP_POLL_E    7'h33
`define SPM_OP_WRITE_E   7'h31
`define SPM_OP_READ_LO   7'h36

// ----------------------------------------------------------------------
// Enter-mode data bytes
// ----------------------------------------------------------------------
`define SPM_MD_ERASE     8'h80
`define SPM_MD_FWR       8'h10
`define SPM_MD_FRD       8'h02
`define SPM_MD_EWR       8'h11
`define SPM_MD_ERD       8'h03

// ----------------------------------------------------------------------
// Memory geometry and result layout
// ----------------------------------------------------------------------
`define SPM_PROG_ADDR_TOP_BIT   4
`define SPM_EEPROM_ADDR_TOP_BIT 3
`define SPM_PROG_WORDS   32
`define SPM_EE_BYTES     16
`define SPM_PAGE_WORDS   4
`define SPM_STATUS_BIT   9
`define SPM_BUSY_CYCLES  8'h20

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SPM_CORE_PERIOD_NS   10
`define SPM_TIMEOUT_SHORT_NS 1000
`define SPM_TIMEOUT_LONG_NS  65000
`define SPM_TIMEOUT_SHORT_CYC \
   (`SPM_TIMEOUT_SHORT_NS / `SPM_CORE_PERIOD_NS)
`define SPM_TIMEOUT_LONG_CYC \
   (`SPM_TIMEOUT_LONG_NS / `SPM_CORE_PERIOD_NS)
`define SPM_HOST_PHASES  2'h3

`endif

// >>> inc/spm_pkg.sv
/*
 Types shared by both ends: mode and host state enums, state structs.
 Assumes spm_defs.svh is on the include path.
*/
`include "spm_defs.svh"

package spm_pkg;

   // -------------------------------------------------------------------
   // Enumerations
   // -------------------------------------------------------------------
   typedef enum logic [5:0] {
      MODE_NONE  = 6'h01,
      MODE_ERASE = 6'h02,
      MODE_FWR   = 6'h04,
      MODE_FRD   = 6'h08,
      MODE_EWR   = 6'h10,
      MODE_ERD   = 6'h20
   } spm_mode_e;

   typedef enum logic [3:0] {
      HS_IDLE  = 4'h1,
      HS_CAPT  = 4'h2,
      HS_SHIFT = 4'h4,
      HS_UPD   = 4'h8
   } spm_hstate_e;

   // -------------------------------------------------------------------
   // Device state on the link clock
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [15:0]                      sh;     // Command shift stage
      logic                             rstBit; // Scan reset register
      logic [15:0]                      key;    // Unlock register
      spm_mode_e                        mode;
      logic [15:0]                      addr;
      logic [7:0]                       dLo;
      logic [7:0]                       dHi;
      logic [7:0]                       resLow; // Result low byte
      logic [7:0]                       busy;   // Write time left
      logic [`SPM_PAGE_WORDS-1:0][15:0] pbuf;
      logic [`SPM_PROG_WORDS-1:0][15:0] pmem;
      logic [`SPM_EE_BYTES-1:0][7:0]    emem;
      logic                             scanDo;
   } spm_dev_link_s;

   // Device state on the core clock
   typedef struct packed {
      logic        s1Rst;
      logic        s2Rst;
      logic        s1En;
      logic        s2En;
      logic [12:0] cnt;
      logic        coreReset;
      logic        progEnabled;
   } spm_dev_core_s;

   // Host state
   typedef struct packed {
      spm_hstate_e st;
      logic [1:0]  ph;
      logic [4:0]  cnt;
      logic [4:0]  len;
      logic [15:0] tx;
      logic [15:0] rx;
      logic        s1Do;
      logic        s2Do;
      logic        scanClk;
      logic [1:0]  scanSel;
      logic        scanCapture;
      logic        scanShift;
      logic        scanUpdate;
      logic        scanDi;
      logic        opReady;
      logic        resultValid;
      logic [15:0] resultData;
   } spm_host_s;

endpackage : spm_pkg

// >>> inc/spm_link_if.sv
/*
 Scan link between host and device. All signals but scanDo are driven
 by the host; device samples them on the rising edge of scanClk.
*/
`timescale 1ns/1ps

interface spm_link_if;
   logic       scanClk;     // Link clock, made by the host
   logic [1:0] scanSel;     // Selected link register
   logic       scanCapture; // Load result into shift stage
   logic       scanShift;   // Shift one bit, LSB first
   logic       scanUpdate;  // Shift complete, execute
   logic       scanDi;      // Data toward the device
   logic       scanDo;      // Data toward the host

   modport dev  (input  scanClk, scanSel, scanCapture, scanShift,
                 input  scanUpdate, scanDi, output scanDo);
   modport host (output scanClk, scanSel, scanCapture, scanShift,
                 output scanUpdate, scanDi, input scanDo);
endinterface : spm_link_if

// >>> src/spm_dev.sv
/*
 Device end: scan reset, unlock and command registers with the program
 memory and EEPROM they reach, plus the core-side reset hold.
 Assumes a host on spm_link_if that makes scanClk and keeps to the
 command order; scanClk may stop between frames.
*/
`timescale 1ns/1ps
`include "spm_defs.svh"

module spm_dev #(
   parameter int LONG_TIMEOUT_CYCLES = `SPM_TIMEOUT_LONG_CYC
) (
   // Core clock and power-on reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Link
   spm_link_if.dev   link,
   // Core side
   input  wire logic clkOption,   // 1 selects the long time-out
   output logic      coreReset,   // Holds the device core in reset
   output logic      progEnabled  // Programming unlocked
);

   // -------------------------------------------------------------------
   // Constants and helpers
   // -------------------------------------------------------------------
   localparam logic [12:0] SHORT_CYC = 13'(`SPM_TIMEOUT_SHORT_CYC);
   localparam logic [12:0] LONG_CYC  = 13'(LONG_TIMEOUT_CYCLES);

   // Word index within a page of a page-aligned base
   function automatic logic [4:0] pageIdx(input logic [4:0] base,
                                          input int         i);
      pageIdx = {base[4:2], 2'(i)};
   endfunction : pageIdx

   spm_pkg::spm_dev_link_s r;       // Link-domain state
   spm_pkg::spm_dev_link_s n;       // Its next value
   spm_pkg::spm_dev_core_s c_reg;   // Core-domain state
   spm_pkg::spm_dev_core_s c_next;  // Its next value

   // -------------------------------------------------------------------
   // Link domain: shift stages and command execution
   // -------------------------------------------------------------------
   // Next-state logic of the scan registers
   always_comb begin
      logic [6:0] opc;
      logic [7:0] dat;
      logic [4:0] pa;
      logic [3:0] ea;
      logic       keyOk;
      logic       idle;
      opc   = r.sh[14:8];
      dat   = r.sh[7:0];
      pa    = r.addr[`SPM_PROG_ADDR_TOP_BIT:0];
      ea    = r.addr[`SPM_EEPROM_ADDR_TOP_BIT:0];
      keyOk = (r.key == `SPM_KEY);
      idle  = (r.busy == 8'h00);
      n     = r;

      // Write time runs down on each rising link edge
      if (!idle) begin
         n.busy = r.busy - 8'h01;
      end

      if (link.scanCapture) begin
         // Result of the previous command, status in bit 9
         if (link.scanSel == `SPM_SEL_CMD) begin
            n.sh                  = {8'h00, r.resLow};
            n.sh[`SPM_STATUS_BIT] = idle;
         end
      end else if (link.scanShift) begin
         case (link.scanSel)
            // No update latch: reset follows the shifted bit
            `SPM_SEL_RST: begin
               n.rstBit = link.scanDi;
            end
            `SPM_SEL_KEY: begin
               n.key = {link.scanDi, r.key[15:1]};
            end
            // LSB first into a 15-bit stage
            `SPM_SEL_CMD: begin
               n.sh = {1'b0, link.scanDi, r.sh[14:1]};
            end
            default: begin
               n.sh = r.sh;
            end
         endcase
      end else if (link.scanUpdate && keyOk &&
                   link.scanSel == `SPM_SEL_CMD) begin
         // Command takes effect only once fully shifted in
         case (opc)
            `SPM_OP_ENTER: begin
               // Mode stays until the next enter command
               case (dat)
                  `SPM_MD_ERASE: n.mode = spm_pkg::MODE_ERASE;
                  `SPM_MD_FWR:   n.mode = spm_pkg::MODE_FWR;
                  `SPM_MD_FRD:   n.mode = spm_pkg::MODE_FRD;
                  `SPM_MD_EWR:   n.mode = spm_pkg::MODE_EWR;
                  `SPM_MD_ERD:   n.mode = spm_pkg::MODE_ERD;
                  default:       n.mode = spm_pkg::MODE_NONE;
               endcase
            end
            `SPM_OP_ADDR_HI: begin
               n.addr[15:8] = dat;
            end
            `SPM_OP_ADDR_LO: begin
               n.addr[7:0] = dat;
            end
            `SPM_OP_DATA_LO: begin
               n.dLo = dat;
            end
            `SPM_OP_DATA_HI: begin
               n.dHi = dat;
            end
            // Strobe word: loaded bytes go into the page buffer
            `SPM_OP_LATCH: begin
               if (r.mode == spm_pkg::MODE_FWR) begin
                  n.pbuf[pa[1:0]] = {r.dHi, r.dLo};
               end else if (r.mode == spm_pkg::MODE_EWR) begin
                  n.pbuf[ea[1:0]] = {8'h00, r.dLo};
               end
            end
            // Program page write; memory updated at start
            `SPM_OP_WRITE_F: begin
               if (r.mode == spm_pkg::MODE_FWR && idle) begin
                  for (int i = 0; i < `SPM_PAGE_WORDS; i++) begin
                     n.pmem[pageIdx(pa, i)] = r.pbuf[i];
                  end
                  n.busy = `SPM_BUSY_CYCLES;
               end
            end
            // EEPROM page write, or chip erase in erase mode
            `SPM_OP_WRITE_E: begin
               if (r.mode == spm_pkg::MODE_EWR && idle) begin
                  for (int i = 0; i < `SPM_PAGE_WORDS; i++) begin
                     n.emem[pageIdx({1'b0, ea}, i)] =
                        r.pbuf[i][7:0];
                  end
                  n.busy = `SPM_BUSY_CYCLES;
               end else if (r.mode == spm_pkg::MODE_ERASE && idle) begin
                  n.pmem = '1;
                  n.emem = '1;
                  n.busy = `SPM_BUSY_CYCLES;
               end
            end
            `SPM_OP_READ_LO: begin
               n.resLow = (r.mode == spm_pkg::MODE_FRD) ?
                          r.pmem[pa][7:0] : 8'h00;
            end
            // High byte in read mode, else a status poll
            `SPM_OP_POLL_F: begin
               n.resLow = (r.mode == spm_pkg::MODE_FRD) ?
                          r.pmem[pa][15:8] : 8'h00;
            end
            `SPM_OP_POLL_E: begin
               n.resLow = (r.mode == spm_pkg::MODE_ERD) ?
                          r.emem[ea] : 8'h00;
            end
            default: begin
               n.resLow = r.resLow;
            end
         endcase
      end

      // Bit 0 of the selected register faces the host
      case (link.scanSel)
         `SPM_SEL_RST: n.scanDo = n.rstBit;
         `SPM_SEL_KEY: n.scanDo = n.key[0];
         default:      n.scanDo = n.sh[0];
      endcase
   end

   // Link-domain flops; key and reset bit clear at power-on
   always_ff @(posedge link.scanClk or posedge reset) begin
      if (reset) begin
         r        <= '0;
         r.mode   <= spm_pkg::MODE_NONE;
         r.pmem   <= '1;
         r.emem   <= '1;
      end else begin
         r <= n;
      end
   end

   assign link.scanDo = r.scanDo;

   // -------------------------------------------------------------------
   // Core domain: synchronisers and reset time-out
   // -------------------------------------------------------------------
   // Levels cross by two flops; the count holds reset after release
   always_comb begin
      c_next       = c_reg;
      c_next.s1Rst = r.rstBit;
      c_next.s2Rst = c_reg.s1Rst;
      c_next.s1En  = (r.key == `SPM_KEY);
      c_next.s2En  = c_reg.s1En;
      if (c_reg.s2Rst) begin
         // Reload while held, so the time-out starts at release
         c_next.cnt = clkOption ? LONG_CYC : SHORT_CYC;
      end else if (c_reg.cnt != 13'h0000) begin
         c_next.cnt = c_reg.cnt - 13'h0001;
      end
      c_next.coreReset   = c_reg.s2Rst ||
                           (c_reg.cnt != 13'h0000);
      c_next.progEnabled = c_reg.s2En;
   end

   // Core-domain flops
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         c_reg <= '0;
      end else begin
         c_reg <= c_next;
      end
   end

   assign coreReset   = c_reg.coreReset;
   assign progEnabled = c_reg.progEnabled;

endmodule : spm_dev

// >>> src/spm_host.sv
/*
 Host end: makes scanClk by dividing core_clk by four and runs one
 capture, shift, update frame per request.
 Assumes the user sequences commands; scanDo is synchronised here.
*/
`timescale 1ns/1ps
`include "spm_defs.svh"

module spm_host (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Link
   spm_link_if.host         link,
   // Request
   input  wire logic        opValid,    // Start a frame
   input  wire logic [1:0]  opSel,      // Register to reach
   input  wire logic [15:0] opData,     // Bits to shift, LSB first
   output logic             opReady,    // Idle, request accepted
   // Answer
   output logic             resultValid, // One-cycle pulse
   output logic [15:0]      resultData   // Bits shifted out
);

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   // Shift length of each link register
   function automatic logic [4:0] lenOf(input logic [1:0] sel);
      case (sel)
         `SPM_SEL_RST: lenOf = `SPM_LEN_RST;
         `SPM_SEL_KEY: lenOf = `SPM_LEN_KEY;
         default:      lenOf = `SPM_LEN_CMD;
      endcase
   endfunction : lenOf

   spm_pkg::spm_host_s r;  // State
   spm_pkg::spm_host_s n;  // Next state

   // -------------------------------------------------------------------
   // Frame sequencer
   // -------------------------------------------------------------------
   // Each link period lasts four core cycles: low at 0-1, high at 2-3
   always_comb begin
      n             = r;
      n.resultValid = 1'b0;
      n.s1Do        = link.scanDo;
      n.s2Do        = r.s1Do;
      case (r.st)
         spm_pkg::HS_IDLE: begin
            // Clock stands still low between frames
            if (opValid) begin
               n.st          = spm_pkg::HS_CAPT;
               n.ph          = 2'h0;
               n.scanSel     = opSel;
               n.len         = lenOf(opSel);
               n.tx          = opData;
               n.rx          = 16'h0000;
               n.scanCapture = 1'b1;
               n.opReady     = 1'b0;
            end
         end
         spm_pkg::HS_CAPT, spm_pkg::HS_SHIFT, spm_pkg::HS_UPD: begin
            n.ph = r.ph + 2'h1;
            if (r.ph == 2'h1) begin
               // Clock high for phases 2-3, so the duty stays even
               n.scanClk = 1'b1;
               // Bit of the previous rise has passed both sync flops
               if (r.st == spm_pkg::HS_SHIFT) begin
                  n.rx = {r.s2Do, r.rx[15:1]};
               end
            end
            if (r.ph == `SPM_HOST_PHASES) begin
               n.scanClk = 1'b0;
               case (r.st)
                  spm_pkg::HS_CAPT: begin
                     n.st          = spm_pkg::HS_SHIFT;
                     n.scanCapture = 1'b0;
                     n.scanShift   = 1'b1;
                     n.scanDi      = r.tx[0];
                     n.cnt         = 5'h00;
                  end
                  spm_pkg::HS_SHIFT: begin
                     if (r.cnt == 5'(r.len - 5'h01)) begin
                        n.st         = spm_pkg::HS_UPD;
                        n.scanShift  = 1'b0;
                        n.scanUpdate = 1'b1;
                     end else begin
                        n.cnt    = r.cnt + 5'h01;
                        n.tx     = {1'b0, r.tx[15:1]};
                        n.scanDi = r.tx[1];
                     end
                  end
                  default: begin
                     // Right-align the bits gathered in the frame
                     n.st          = spm_pkg::HS_IDLE;
                     n.scanUpdate  = 1'b0;
                     n.scanDi      = 1'b0;
                     n.opReady     = 1'b1;
                     n.resultValid = 1'b1;
                     n.resultData  = r.rx >> (`SPM_SHIFT_W - r.len);
                  end
               endcase
            end
         end
         default: begin
            n.st = spm_pkg::HS_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         r         <= '0;
         r.st      <= spm_pkg::HS_IDLE;
         r.opReady <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // -------------------------------------------------------------------
   // Outputs, all from flops
   // -------------------------------------------------------------------
   assign link.scanClk     = r.scanClk;
   assign link.scanSel     = r.scanSel;
   assign link.scanCapture = r.scanCapture;
   assign link.scanShift   = r.scanShift;
   assign link.scanUpdate  = r.scanUpdate;
   assign link.scanDi      = r.scanDi;
   assign opReady          = r.opReady;
   assign resultValid      = r.resultValid;
   assign resultData       = r.resultData;

endmodule : spm_host

// >>> verification/spm_assertions.sv
/*
 Checker of the scan link and the core reset and unlock outputs.
 Assumes the bench instantiates it beside the link interface.
*/
`timescale 1ns/1ps
`include "spm_defs.svh"

module spm_assertions #(
   parameter int LONG_TIMEOUT_CYCLES = 20
) (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       reset,
   // Link
   input wire logic       scanClk,
   input wire logic [1:0] scanSel,
   input wire logic       scanCapture,
   input wire logic       scanShift,
   input wire logic       scanUpdate,
   input wire logic       scanDi,
   // Core side
   input wire logic       clkOption,
   input wire logic       coreReset,
   input wire logic       progEnabled
);
   // ------------------------------------------------------------------
   // Helper counters
   // ------------------------------------------------------------------
   logic [15:0] shiftCnt; // Cycles of the running shift
   logic [15:0] holdCnt;  // Cycles the core has been held

   // Counts restart whenever their signal drops
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         shiftCnt <= 16'h0000;
         holdCnt  <= 16'h0000;
      end else begin
         shiftCnt <= scanShift ? shiftCnt + 16'h0001 : 16'h0000;
         holdCnt  <= coreReset ? holdCnt + 16'h0001 : 16'h0000;
      end
   end

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   chk_capture_width: assert property (
      $rose(scanCapture) |-> scanCapture[*4] ##1 (!scanCapture && scanShift))
      else $error("capture not one link period");
   chk_cmd_length: assert property (
      $fell(scanShift) && scanSel == `SPM_SEL_CMD |-> shiftCnt == 16'h003C)
      else $error("command shift not fifteen bits");
   chk_update_after: assert property (
      $fell(scanShift) |-> scanUpdate[*4] ##1 !scanUpdate)
      else $error("update does not follow shift");
   chk_clock_shape: assert property (
      $rose(scanClk) |-> scanClk[*2] ##1 !scanClk[*2])
      else $error("link clock not core clock by four");
   chk_reset_fast: assert property (
      $rose(scanClk) && scanShift && scanSel == `SPM_SEL_RST && scanDi
      |-> ##[1:8] coreReset)
      else $error("core reset late after reset bit");
   chk_reset_source: assert property (
      $rose(coreReset) |-> scanSel == `SPM_SEL_RST)
      else $error("core reset without reset register");
   chk_hold_time: assert property (
      $fell(coreReset) |-> holdCnt >=
      (clkOption ? LONG_TIMEOUT_CYCLES : `SPM_TIMEOUT_SHORT_CYC))
      else $error("core reset released before time-out");
   chk_unlock_sel: assert property (
      $changed(progEnabled) |-> scanSel == `SPM_SEL_KEY)
      else $error("unlock changed outside key access");
endmodule : spm_assertions

// >>> verification/tb_scan_port_memory_programming.sv
/*
 Bench: host and device joined by the link; commands from a table.
 Assumes the design files and spm_defs.svh on the include path.
*/
`timescale 1ns/1ps
`include "spm_defs.svh"

module tb_scan_port_memory_programming;
   logic        core_clk  = 1'b0;     // 100 MHz core clock
   logic        reset     = 1'b1;     // Power-on reset
   logic        clkOption = 1'b0;     // Short time-out first
   logic        opValid   = 1'b0;     // Host request
   logic [1:0]  opSel     = 2'h0;
   logic [15:0] opData    = 16'h0000;
   logic        opReady, resultValid, coreReset, progEnabled;
   logic [15:0] resultData;
   int          n_mismatch      = 0;
   int          samples_checked = 0;
   // Rows: kind (1 done, 2 byte, 3 busy), expected byte, opcode, data
   logic [27:0] rows [0:51] = '{
      28'h0002310, 28'h0000700, 28'h0000325, 28'h000135A, 28'h00017C3,
      // Latch left opcode 0x37 set, so the write opener is skipped
      28'h0003700, 28'h0007700, 28'h0003700, 28'h0003500, 28'h3003700,
      28'h0003700, 28'h0003700, 28'h0003700, 28'h1003700, 28'h0002302,
      28'h00007FF, 28'h0000305, 28'h0003200, 28'h0003600, 28'h25A3700,
      28'h2C33700, 28'h0002311, 28'h0000700, 28'h0000313, 28'h00013A5,
      28'h0003700, 28'h0007700, 28'h0003700, 28'h0003300, 28'h0003100,
      28'h0003300, 28'h0003300, 28'h0003300, 28'h1003300, 28'h0002303,
      28'h0000700, 28'h0000303, 28'h0003300, 28'h2A53300, 28'h0002380,
      28'h0003180, 28'h0003380, 28'h0003380, 28'h0003380, 28'h1003380,
      28'h0002302, 28'h0000700, 28'h0000305, 28'h0003600, 28'h2FF3700,
      28'h0002300, 28'h0003300};

   // ------------------------------------------------------------------
   // Ends, link and checker
   // ------------------------------------------------------------------
   spm_link_if link ();
   spm_dev #(.LONG_TIMEOUT_CYCLES(20)) spm_dev_inst (.core_clk, .reset,
      .link(link), .clkOption, .coreReset, .progEnabled);
   spm_host spm_host_inst (.core_clk, .reset, .link(link), .opValid,
      .opSel, .opData, .opReady, .resultValid, .resultData);
   spm_assertions #(.LONG_TIMEOUT_CYCLES(20)) spm_assertions_inst (
      .core_clk, .reset, .scanClk(link.scanClk), .scanSel(link.scanSel),
      .scanCapture(link.scanCapture), .scanShift(link.scanShift),
      .scanUpdate(link.scanUpdate), .scanDi(link.scanDi), .clkOption,
      .coreReset, .progEnabled);

   // Free-running core clock
   always #5 core_clk = ~core_clk;

   // Value compare, four-state exact
   task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   // Counts, verdict, end of run
   task automatic final_report(input bit timedOut);
      if (timedOut)
         n_mismatch++;
      $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report

   // One frame from a falling edge; four spare cycles let syncs settle
   task automatic frame(input logic [1:0] sel, input logic [15:0] data);
      int k;
      opSel   = sel;
      opData  = data;
      opValid = 1'b1;
      @(negedge core_clk);
      opValid = 1'b0;
      cmp("opReady", 16'h0000, {15'h0000, opReady});
      for (k = 0; k < 100 && resultValid !== 1'b1; k++)
         @(negedge core_clk);
      if (k == 100)
         final_report(1'b1);
      repeat (4) @(negedge core_clk);
   endtask : frame

   // Bounded wait for the core to leave reset
   task automatic wait_free(input int n);
      int k;
      for (k = 0; k < n && coreReset !== 1'b0; k++)
         @(negedge core_clk);
      cmp("coreReset", 16'h0000, {15'h0000, coreReset});
   endtask : wait_free

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      logic [27:0] r;
      repeat (4) @(negedge core_clk);
      cmp("progEnabled", 16'h0000, {15'h0000, progEnabled});
      reset = 1'b0;
      frame(`SPM_SEL_RST, 16'h0001);
      cmp("coreReset", 16'h0001, {15'h0000, coreReset});
      frame(`SPM_SEL_KEY, 16'hA371);
      cmp("progEnabled", 16'h0000, {15'h0000, progEnabled});
      frame(`SPM_SEL_KEY, `SPM_KEY);
      cmp("progEnabled", 16'h0001, {15'h0000, progEnabled});
      foreach (rows[i]) begin
         r = rows[i];
         frame(`SPM_SEL_CMD, {1'b0, r[14:0]});
         if (r[27:24] == 4'h1)
            cmp("done", 16'h0200, resultData & 16'h0200);
         if (r[27:24] == 4'h3)
            cmp("busy", 16'h0000, resultData & 16'h0200);
         if (r[27:24] == 4'h2)
            cmp("byte", {8'h00, r[23:16]}, {8'h00, resultData[7:0]});
      end
      // Leaving programming: key cleared, reset released
      frame(`SPM_SEL_KEY, 16'h0000);
      cmp("progEnabled", 16'h0000, {15'h0000, progEnabled});
      frame(`SPM_SEL_RST, 16'h0000);
      repeat (60) @(negedge core_clk);
      cmp("coreReset", 16'h0001, {15'h0000, coreReset});
      wait_free(80);
      clkOption = 1'b1;
      frame(`SPM_SEL_RST, 16'h0001);
      frame(`SPM_SEL_RST, 16'h0000);
      wait_free(40);
      // Power-on reset in mid-run clears the key
      frame(`SPM_SEL_KEY, `SPM_KEY);
      reset = 1'b1;
      @(negedge core_clk);
      reset = 1'b0;
      // An uncleared key would reach progEnabled within three cycles
      repeat (4) @(negedge core_clk);
      cmp("progEnabled", 16'h0000, {15'h0000, progEnabled});
      final_report(1'b0);
   end
endmodule : tb_scan_port_memory_programming
